// *** bcrc_consts.vh ***
`ifndef BCRC_CONSTS_VH
`define BCRC_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BCRC_SYSCFG_OFS    12'h000
`define BCRC_STATUS_OFS    12'h004
`define BCRC_CLKPER_OFS    12'h008
// ----------------------------------------
// field positions
// ----------------------------------------
`define BCRC_CFG_HBW_BIT   0
`define BCRC_CFG_SDC1_BIT  1
`define BCRC_ST_MODE_LO    0
`define BCRC_ST_CAPT_BIT   2
`define BCRC_ST_BOOT_BIT   3
`define BCRC_ST_LOCK_BIT   4
`define BCRC_ST_FAULT_BIT  5
`define BCRC_ST_MSTR_BIT   6
`define BCRC_ST_CRYSTAL_TERMINAL_BIT   7
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define BCRC_SYSCFG_RST    2'h0
`define BCRC_MODE_EXT      2'h0
`define BCRC_MODE_HOST     2'h1
`define BCRC_MODE_EPROM    2'h2
`define BCRC_ID_SINGLE     2'h0
`define BCRC_CLK_MULT      2
`define BCRC_RESET_VECTOR  32'h00020004
`define BCRC_EXTMEM_START  32'h00400000
// ----------------------------------------
// sys_clk frequency and timing counts (sys_clk cycles)
// ----------------------------------------
`define BCRC_SYS_CLK_MHZ   100
`define BCRC_IN_PER_CYC    8'h04
`define BCRC_IN_MAX_CYC    8'h10
`endif

// *** bcrc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcrc_partner #(
   parameter int LOAD_CYC = 40
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // clock source and boot loader
   output var  logic clock_input,
   output var  logic eprom_access_req,
   output var  logic boot_load_done
);
   logic [1:0] div_r;
   int         load_r;
   // 1x source at a quarter of sys_clk, never halted or slowed
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_r <= 2'h0;
         clock_input <= 1'b0;
         load_r <= 0;
      end else begin
         div_r <= div_r + 2'h1;
         clock_input <= div_r[1];
         if (load_r < LOAD_CYC) load_r <= load_r + 1;
      end
   end
   assign eprom_access_req = !rst && load_r < LOAD_CYC;
   assign boot_load_done = load_r == LOAD_CYC - 1;
endmodule // bcrc_partner
`default_nettype wire

// *** bcrc_top.v ***
// Notes on behaviour
// - with boot source select high, drive boot memory select as EPROM chip select.
// - in multiprocessor systems only the current bus master drives boot memory select.
// - select 0 and memory select 0: no boot, fetch from external memory.
// - select 0 and memory select 1: host boot, width from configuration bit.
// - boot memory select pin is driven only in EPROM mode, by the bus master, where it is output.
// - clock generator doubles the input clock for core and SDRAM.
// - doubled clock is presented on the SDRAM clock output pins.
// - external clock with open crystal terminal also runs core at twice input.
// - reset returns to known state, then execution starts at reset vector after host or EPROM boot.
// - bus master indicator high exactly while owning the shared bus; the registered pin trails ownership by one sys_clk edge.
// - identifier 00 means single processor; indicator held high.
// - high select boots 8-bit EPROM; low lets memory select decide.
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_consts.vh"

module bcrc_top (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // boot straps and boot memory select pin
   input  wire        boot_source_select,
   input  wire        boot_memory_select_in,
   output reg         boot_memory_select_out,
   output reg         boot_memory_select_oe,
   input  wire        eprom_access_req,
   input  wire        boot_load_done,
   // clock pins
   input  wire        clock_input,
   input  wire        crystal_present,
   output reg  [1:0]  sdram_clock_out,
   output reg  [1:0]  sdram_clock_oe,
   // multiprocessing
   input  wire [1:0]  processor_identifier,
   input  wire        bus_grant,
   output reg         bus_master_indicator,
   // core control
   output reg  [1:0]  boot_mode,
   output reg         host_bus_width,
   output reg         core_run,
   output reg         core_start,
   output reg  [31:0] fetch_addr
);

   // ----------------------------------------
   // boot decode
   // ----------------------------------------
   // one decode shared by capture and the mode output
   function [1:0] bcrc_mode;
      input sel;
      input boot_memory_select;
      begin
         if (sel) begin
            bcrc_mode = `BCRC_MODE_EPROM;
         end else if (boot_memory_select) begin
            bcrc_mode = `BCRC_MODE_HOST;
         end else begin
            bcrc_mode = `BCRC_MODE_EXT;
         end
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   // strap capture and boot progress
   reg        captured_r;
   reg        booting_r;
   reg [1:0]  mode_r;

   // software configuration and sticky clock fault
   reg [1:0]  cfg_r;
   reg        fault_r;

   // input clock period monitor
   reg        locked_r;
   reg [7:0]  per_r;
   reg [7:0]  cnt_r;
   reg        cin_q_r;

   // bus ownership and sdram clock phase
   reg        master_nxt;
   reg        sd_ph_r;

   // bus strobes
   wire       wr_en;
   wire       rd_en;
   wire       ok_ofs;

   // clock monitor events
   wire       cin_rise;
   wire       fault_set;
   wire       fault_clr;

   // a write lands only on the edge that completes the access
   assign wr_en    = psel & penable & pready & pwrite;
   // read data is latched in setup so it stands through the access cycle
   assign rd_en    = psel & ~penable & ~pwrite;
   assign ok_ofs   = (paddr == `BCRC_SYSCFG_OFS) | (paddr == `BCRC_STATUS_OFS) |
                     (paddr == `BCRC_CLKPER_OFS);

   // high in the same sys_clk cycle as the pin, against the pin's sample one edge earlier
   assign cin_rise = clock_input & ~cin_q_r;
   // wrong period or stall, but only once locked; start-up is no fault
   assign fault_set = locked_r & ((cin_rise & (cnt_r != `BCRC_IN_PER_CYC)) |
                      (cnt_r >= `BCRC_IN_MAX_CYC));
   // write one to clear
   assign fault_clr = wr_en & (paddr == `BCRC_STATUS_OFS) & pwdata[`BCRC_ST_FAULT_BIT];

   // ----------------------------------------
   // bus ownership
   // ----------------------------------------
   // identifier 00 marks a single-processor system, which owns the bus for good
   // others follow the arbiter's grant
   always @* begin
      if (processor_identifier == `BCRC_ID_SINGLE) begin
         master_nxt = 1'b1;
      end else begin
         master_nxt = bus_grant;
      end
   end

   // registered so the pin never glitches while the grant settles
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bus_master_indicator <= 1'b0;
      end else begin
         bus_master_indicator <= master_nxt;
      end
   end

   // ----------------------------------------
   // strap capture and boot sequence
   // ----------------------------------------
   // straps are caught on the first edge after release, never loaded by the
   // async reset itself; hard-wired straps make the one-edge delay harmless
   // limitation: straps are read once per reset; later changes are ignored
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         captured_r <= 1'b0;
         booting_r  <= 1'b0;
         mode_r     <= `BCRC_MODE_EXT;
         core_run   <= 1'b0;
         core_start <= 1'b0;
         fetch_addr <= `BCRC_RESET_VECTOR;
      end else begin
         core_start <= 1'b0;
         if (!captured_r) begin
            captured_r <= 1'b1;
            mode_r     <= bcrc_mode(boot_source_select, boot_memory_select_in);
            booting_r  <= boot_source_select | boot_memory_select_in;
            if (!boot_source_select && !boot_memory_select_in) begin
               fetch_addr <= `BCRC_EXTMEM_START;
               core_run   <= 1'b1;
               core_start <= 1'b1;
            end else begin
               fetch_addr <= `BCRC_RESET_VECTOR;
            end
         // host and eprom boots hold the core until the loader reports done
         end else if (booting_r && boot_load_done) begin
            booting_r  <= 1'b0;
            core_run   <= 1'b1;
            core_start <= 1'b1;
         end
      end
   end

   // mode and width outputs trail the internal state by one edge
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         boot_mode      <= `BCRC_MODE_EXT;
         host_bus_width <= 1'b0;
      end else begin
         boot_mode      <= mode_r;
         host_bus_width <= cfg_r[`BCRC_CFG_HBW_BIT];
      end
   end

   // ----------------------------------------
   // boot memory select pin
   // ----------------------------------------
   // only an EPROM-mode master ever drives it; in other modes it stays an input
   // chip select is active low and idles high outside loader reads
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         boot_memory_select_out <= 1'b1;
         boot_memory_select_oe  <= 1'b0;
      end else begin
         boot_memory_select_oe  <= captured_r & (mode_r == `BCRC_MODE_EPROM) & master_nxt;
         boot_memory_select_out <= ~(booting_r & eprom_access_req);
      end
   end

   // ----------------------------------------
   // clock doubling and monitor
   // ----------------------------------------
   // sys_clk is the generator's fast clock, four cycles per input period;
   // a toggle per edge gives twice the input rate once the period is locked
   // period is measured between rising edges of the input clock
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cin_q_r  <= 1'b0;
         cnt_r    <= 8'h00;
         per_r    <= 8'h00;
         locked_r <= 1'b0;
      end else begin
         cin_q_r <= clock_input;
         if (cin_rise) begin
            cnt_r    <= 8'h01;
            per_r    <= cnt_r;
            locked_r <= (cnt_r == `BCRC_IN_PER_CYC);
         end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
         end
         // the count saturates, so a halted input reads as a stall, never a lock
         if (cnt_r >= `BCRC_IN_MAX_CYC) begin
            locked_r <= 1'b0;
         end
      end
   end

   // sticky: a new fault in the clearing cycle wins
   // software clears with a one, so a stray zero write never hides a fault
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_r <= 1'b0;
      end else if (fault_set) begin
         fault_r <= 1'b1;
      end else if (fault_clr) begin
         fault_r <= 1'b0;
      end
   end

   // output 1 can be turned off by software for light loads; output 0 follows lock
   // the phase restarts from low whenever lock is lost
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sd_ph_r         <= 1'b0;
         sdram_clock_out <= 2'h0;
         sdram_clock_oe  <= 2'h0;
      end else begin
         sd_ph_r         <= locked_r ? ~sd_ph_r : 1'b0;
         sdram_clock_out <= {2{sd_ph_r}};
         sdram_clock_oe  <= {~cfg_r[`BCRC_CFG_SDC1_BIT] & locked_r, locked_r};
      end
   end

   // ----------------------------------------
   // apb register file
   // ----------------------------------------
   // zero wait: pready rises in the access cycle right after setup
   // prdata is registered and only meaningful while pready is high
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         cfg_r   <= `BCRC_SYSCFG_RST;
      end else begin
         pready  <= psel & ~penable;
         // unmapped offsets answer with an error and read as zero
         pslverr <= psel & ~penable & ~ok_ofs;
         if (wr_en && paddr == `BCRC_SYSCFG_OFS) begin
            cfg_r <= pwdata[1:0];
         end
         if (rd_en) begin
            case (paddr)
               `BCRC_SYSCFG_OFS: begin
                  prdata <= {30'h00000000, cfg_r};
               end
               `BCRC_STATUS_OFS: begin
                  prdata <= {24'h000000, crystal_present, bus_master_indicator, fault_r,
                             locked_r, booting_r, captured_r, mode_r};
               end
               `BCRC_CLKPER_OFS: begin
                  prdata <= {24'h000000, per_r};
               end
               default: begin
                  prdata <= 32'h00000000;
               end
            endcase
         // idle bus reads as zero so stale data never lingers
         end else if (!psel) begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule // bcrc_top
`default_nettype wire

// *** bcrc_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_consts.vh"
module bcrc_top_sva (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // straps and pins
   input wire logic        boot_source_select,
   input wire logic        boot_memory_select_in,
   input wire logic        boot_memory_select_oe,
   input wire logic [1:0]  processor_identifier,
   input wire logic        bus_grant,
   input wire logic        bus_master_indicator,
   input wire logic [1:0]  sdram_clock_out,
   input wire logic [1:0]  sdram_clock_oe,
   // core control
   input wire logic [1:0]  boot_mode,
   input wire logic        core_start,
   input wire logic [31:0] fetch_addr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // past values still see reset for three edges
   sequence settled;
      !$past(rst) && !$past(rst, 2) && !$past(rst, 3);
   endsequence
   sequence was_master;
      $past(processor_identifier) == `BCRC_ID_SINGLE || $past(bus_grant);
   endsequence
   a_oe_only_eprom: assert property (boot_memory_select_oe |-> boot_mode == `BCRC_MODE_EPROM)
      else $error("select pin driven outside eprom mode");
   a_oe_master_only: assert property (boot_memory_select_oe |-> was_master)
      else $error("select pin driven while not bus master");
   a_oe_eprom_drive: assert property (settled ##0 boot_mode == `BCRC_MODE_EPROM ##0 was_master
      |-> boot_memory_select_oe) else $error("select pin not driven in eprom mode");
   a_mstr_single: assert property (settled ##0 was_master ##0 $past(processor_identifier) == 2'h0
      |-> bus_master_indicator) else $error("indicator low in single system");
   a_mstr_follow: assert property (settled ##0 $past(processor_identifier) != 2'h0
      |-> bus_master_indicator == $past(bus_grant)) else $error("indicator not tracking grant");
   a_ext_fetch: assert property (core_start && boot_mode == `BCRC_MODE_EXT
      |-> fetch_addr == `BCRC_EXTMEM_START) else $error("wrong external start");
   a_sdclk_toggle: assert property (sdram_clock_oe[0] [*3] |-> sdram_clock_out[0] != $past(sdram_clock_out[0]))
      else $error("sdram clock not toggling");
   a_mode_decode: assert property (settled |-> boot_mode == (boot_source_select ? `BCRC_MODE_EPROM :
      boot_memory_select_in ? `BCRC_MODE_HOST : `BCRC_MODE_EXT)) else $error("boot mode mismatch");
endmodule // bcrc_top_sva
bind bcrc_top bcrc_top_sva bcrc_top_sva_i (.sys_clk, .rst, .boot_source_select, .boot_memory_select_in,
   .boot_memory_select_oe, .processor_identifier, .bus_grant, .bus_master_indicator, .sdram_clock_out,
   .sdram_clock_oe, .boot_mode, .core_start, .fetch_addr);
`default_nettype wire

// *** boot_clock_reset_config_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_consts.vh"
module boot_clock_reset_config_test;
   logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, fetch_addr, rdat;
   logic        pready, pslverr, rerr, boot_memory_select_out, boot_memory_select_oe, bus_master_indicator;
   logic        boot_source_select = 1'b0, boot_memory_select_in = 1'b0, crystal_present = 1'b0;
   logic        bus_grant = 1'b0, eprom_access_req, boot_load_done, clock_input, host_bus_width;
   logic        core_run, core_start;
   logic [1:0]  processor_identifier = 2'h0, sdram_clock_out, sdram_clock_oe, boot_mode;
   int          err_total = 0, num_checks = 0;
   bcrc_top bcrc_top_i (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .boot_source_select, .boot_memory_select_in, .boot_memory_select_out,
      .boot_memory_select_oe, .eprom_access_req, .boot_load_done, .clock_input, .crystal_present,
      .sdram_clock_out, .sdram_clock_oe, .processor_identifier, .bus_grant, .bus_master_indicator,
      .boot_mode, .host_bus_width, .core_run, .core_start, .fetch_addr);
   bcrc_partner bcrc_partner_i (.sys_clk, .rst, .clock_input, .eprom_access_req, .boot_load_done);
   always #5 sys_clk = ~sys_clk;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wrap_up;
      if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // straps change only while reset is held
   task automatic boot(input logic bs, input logic bm, input logic [1:0] id);
      @(posedge sys_clk);
      rst <= 1'b1;
      boot_source_select <= bs;
      boot_memory_select_in <= bm;
      processor_identifier <= id;
      repeat (8) @(posedge sys_clk);
      chk(fetch_addr, `BCRC_RESET_VECTOR);
      chk(core_run, 1'b0);
      rst <= 1'b0;
   endtask
   task automatic wait_start;
      int n;
      n = 0;
      while (core_start !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n < 200, 1'b1);
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      boot(1'b0, 1'b0, 2'h0);
      wait_start();
      chk(fetch_addr, `BCRC_EXTMEM_START);
      repeat (60) @(posedge sys_clk);
      chk(bus_master_indicator, 1'b1);
      chk(boot_memory_select_oe, 1'b0);
      chk(sdram_clock_oe[0], 1'b1);
      apb(1'b0, `BCRC_STATUS_OFS, 32'h0);
      chk(rdat[7:0], 8'h54);
      apb(1'b0, `BCRC_CLKPER_OFS, 32'h0);
      chk(rdat[7:0], `BCRC_IN_PER_CYC);
      apb(1'b1, `BCRC_SYSCFG_OFS, 32'h1);
      apb(1'b0, `BCRC_SYSCFG_OFS, 32'h0);
      chk(rdat, 32'h1);
      chk(host_bus_width, 1'b1);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rerr, 1'b1);
      chk(rdat, 32'h0);
      boot(1'b0, 1'b1, 2'h0);
      repeat (3) @(posedge sys_clk);
      chk(boot_mode, `BCRC_MODE_HOST);
      chk(core_run, 1'b0);
      wait_start();
      chk(core_run, 1'b1);
      chk(boot_memory_select_oe, 1'b0);
      boot(1'b1, 1'b0, 2'h1);
      repeat (4) @(posedge sys_clk);
      chk(boot_mode, `BCRC_MODE_EPROM);
      chk(boot_memory_select_oe, 1'b0);
      chk(bus_master_indicator, 1'b0);
      bus_grant <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(boot_memory_select_oe, 1'b1);
      chk(boot_memory_select_out, 1'b0);
      chk(bus_master_indicator, 1'b1);
      bus_grant <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(boot_memory_select_oe, 1'b0);
      chk(bus_master_indicator, 1'b0);
      boot(1'b1, 1'b0, 2'h0);
      repeat (4) @(posedge sys_clk);
      chk(boot_memory_select_oe, 1'b1);
      chk(boot_memory_select_out, 1'b0);
      chk(bus_master_indicator, 1'b1);
      wait_start();
      repeat (2) @(posedge sys_clk);
      chk(boot_memory_select_out, 1'b1);
      wrap_up();
   end
   // run needs about two hundred cycles
   initial begin
      #50000;
      err_total++;
      wrap_up();
   end
endmodule // boot_clock_reset_config_test
`default_nettype wire
